// >>> hdl/fepcs_pkg.sv
package fepcs_pkg;
  // clock and line timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int IDLE_WINDOW_US = 40;
  localparam int WD_CYCLES = (IDLE_WINDOW_US * 1000) / CLK_PERIOD_NS;
  localparam logic [9:0] WD_LIMIT = 10'(WD_CYCLES);
  localparam logic [4:0] SYNC_RUN = 5'h1E;
  localparam logic signed [5:0] SLICE_TH = 6'sh10;
  localparam logic [2:0] GRP_LAST = 3'h4;

  // code groups
  localparam logic [4:0] CG_I = 5'h1F;
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0D;
  localparam logic [4:0] CG_R = 5'h07;
  localparam logic [4:0] CG_H = 5'h04;
  localparam logic [3:0] NIB_PRE = 4'h5;
  localparam logic [3:0] NIB_BAD_SSD = 4'hE;

  // line levels
  localparam logic [1:0] LVL_ZERO = 2'h0;
  localparam logic [1:0] LVL_PLUS = 2'h1;
  localparam logic [1:0] LVL_MINUS = 2'h3;

  typedef enum logic [1:0] {TX_IDLE, TX_K, TX_DATA, TX_R} fepcs_tx_st_t;
  typedef enum logic [1:0] {RX_IDLE, RX_SSD, RX_FRAME, RX_END} fepcs_rx_st_t;

  function automatic logic [4:0] enc5(input logic [3:0] nib);
    logic [4:0] c;
    c = 5'h1E;
    unique case (nib)
      4'h0: c = 5'h1E;
      4'h1: c = 5'h09;
      4'h2: c = 5'h14;
      4'h3: c = 5'h15;
      4'h4: c = 5'h0A;
      4'h5: c = 5'h0B;
      4'h6: c = 5'h0E;
      4'h7: c = 5'h0F;
      4'h8: c = 5'h12;
      4'h9: c = 5'h13;
      4'hA: c = 5'h16;
      4'hB: c = 5'h17;
      4'hC: c = 5'h1A;
      4'hD: c = 5'h1B;
      4'hE: c = 5'h1C;
      4'hF: c = 5'h1D;
    endcase
    return c;
  endfunction

  // returns {data_valid, nibble}
  function automatic logic [4:0] dec4(input logic [4:0] cg);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (enc5(4'(i)) == cg) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  // seed never all zero, so the stream cannot lock up
  function automatic logic [10:0] seed_of(input logic [4:0] addr);
    return {1'b1, addr, ~addr};
  endfunction
endpackage

// >>> hdl/fepcs_coding.sv
`timescale 1ns/1ns
// Contract
// - invalid groups raise rx_er, never transmitted
// - scrambler seed from phy address
// - scrambler serialises five-bit groups
// - serial nrzi then mlt3 output
// - mlt3 steps on one, holds on zero
// - one six-bit sample per cycle
// - mlt3 levels back to nrzi bits
// - descramble and deserialise stream
// - key acquired on idle, then held
// - idle watchdog forty microseconds
// - watchdog expiry aborts, restarts sync
// - j/k sets group alignment per frame
// - valid groups decoded onto rxd
// - j/k delivered as 0101 0101
// - good delimiter raises rx_dv
// - t/r or two idles end frame
// - other in-frame groups are errors
// - in-frame error asserts rx_er
// - bad delimiter: rx_er, rxd 1110, no dv
// - tx_en rise sends j then k
// - tx_en fall sends t then r
// - idle sent between frames
// - tx_er sends error group
module fepcs_coding (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // configuration pins
  input wire logic [4:0] phy_addr,
  // mii transmit side
  input wire logic tx_en,
  input wire logic tx_er,
  input wire logic [3:0] txd,
  output logic tx_nib_req,
  // line side
  output logic [1:0] mlt3_level,
  input wire logic [5:0] rx_sample,
  // mii receive side
  output logic [3:0] rxd,
  output logic rx_dv,
  output logic rx_er,
  output logic crs,
  output logic rx_nib_valid,
  output logic rx_locked
);

  // address pins come from outside this domain
  logic [4:0] addr_s1, addr_s2;
  always_ff @(posedge ref_clk) begin
    addr_s1 <= phy_addr;
    addr_s2 <= addr_s1;
  end

  // ---------------- transmit ----------------
  fepcs_pkg::fepcs_tx_st_t tx_st, next_tx_st;
  logic [2:0] tx_cnt, next_tx_cnt;
  logic [4:0] tx_grp, next_tx_grp;
  logic [10:0] tx_lfsr, next_tx_lfsr;
  logic nrzi, next_nrzi;
  logic [1:0] mlt_ph, next_mlt_ph;
  logic [1:0] next_mlt3_level;
  logic next_tx_nib_req;
  logic tx_load, tx_key, tx_line_bit;

  always_comb begin
    tx_load = (tx_cnt == fepcs_pkg::GRP_LAST);
    next_tx_cnt = tx_load ? 3'h0 : tx_cnt + 3'h1;
    next_tx_nib_req = (next_tx_cnt == fepcs_pkg::GRP_LAST);
    next_tx_st = tx_st;
    next_tx_grp = tx_grp;
    if (tx_load) begin
      unique case (tx_st)
        fepcs_pkg::TX_IDLE: begin
          if (tx_en) begin
            next_tx_grp = fepcs_pkg::CG_J;
            next_tx_st = fepcs_pkg::TX_K;
          end else begin
            next_tx_grp = fepcs_pkg::CG_I;
          end
        end
        fepcs_pkg::TX_K: begin
          next_tx_grp = fepcs_pkg::CG_K;
          next_tx_st = fepcs_pkg::TX_DATA;
        end
        fepcs_pkg::TX_DATA: begin
          if (!tx_en) begin
            next_tx_grp = fepcs_pkg::CG_T;
            next_tx_st = fepcs_pkg::TX_R;
          end else if (tx_er) begin
            next_tx_grp = fepcs_pkg::CG_H;
          end else begin
            next_tx_grp = fepcs_pkg::enc5(txd);
          end
        end
        fepcs_pkg::TX_R: begin
          next_tx_grp = fepcs_pkg::CG_R;
          next_tx_st = fepcs_pkg::TX_IDLE;
        end
      endcase
    end
    // serial scrambling, msb of group first
    tx_key = tx_lfsr[10] ^ tx_lfsr[8];
    next_tx_lfsr = {tx_lfsr[9:0], tx_key};
    tx_line_bit = tx_grp[3'h4 - tx_cnt] ^ tx_key;
    // nrzi toggle drives the mlt3 step
    next_nrzi = nrzi ^ tx_line_bit;
    next_mlt_ph = (next_nrzi != nrzi) ? mlt_ph + 2'h1 : mlt_ph;
    unique case (next_mlt_ph)
      2'h1: next_mlt3_level = fepcs_pkg::LVL_PLUS;
      2'h3: next_mlt3_level = fepcs_pkg::LVL_MINUS;
      default: next_mlt3_level = fepcs_pkg::LVL_ZERO;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_st <= fepcs_pkg::TX_IDLE;
      tx_cnt <= 3'h0;
      tx_grp <= fepcs_pkg::CG_I;
      // seed held while reset is asserted
      tx_lfsr <= fepcs_pkg::seed_of(addr_s2);
      nrzi <= 1'b0;
      mlt_ph <= 2'h0;
      mlt3_level <= fepcs_pkg::LVL_ZERO;
      tx_nib_req <= 1'b0;
    end else begin
      tx_st <= next_tx_st;
      tx_cnt <= next_tx_cnt;
      tx_grp <= next_tx_grp;
      tx_lfsr <= next_tx_lfsr;
      nrzi <= next_nrzi;
      mlt_ph <= next_mlt_ph;
      mlt3_level <= next_mlt3_level;
      tx_nib_req <= next_tx_nib_req;
    end
  end

  // ---------------- receive line and descrambler ----------------
  logic [1:0] rx_lvl, next_rx_lvl, rx_lvl_d;
  logic rx_nrzi, next_rx_nrzi, rx_nrzi_d;
  logic [10:0] rx_lfsr, next_rx_lfsr;
  logic [4:0] run, next_run;
  logic [9:0] wd_cnt, next_wd_cnt;
  logic [9:0] win, next_win;
  logic next_locked, rx_bit, rx_pred, wd_expire;

  always_comb begin
    if ($signed(rx_sample) > fepcs_pkg::SLICE_TH) begin
      next_rx_lvl = fepcs_pkg::LVL_PLUS;
    end else if ($signed(rx_sample) < -fepcs_pkg::SLICE_TH) begin
      next_rx_lvl = fepcs_pkg::LVL_MINUS;
    end else begin
      next_rx_lvl = fepcs_pkg::LVL_ZERO;
    end
    next_rx_nrzi = rx_nrzi ^ (rx_lvl != rx_lvl_d);
    rx_bit = rx_nrzi ^ rx_nrzi_d;
    rx_pred = rx_lfsr[10] ^ rx_lfsr[8];
    wd_expire = rx_locked && (wd_cnt >= fepcs_pkg::WD_LIMIT);
    next_locked = rx_locked;
    next_run = run;
    next_wd_cnt = wd_cnt;
    next_win = win;
    if (!rx_locked) begin
      // idle means plain ones, so the line bit inverted is the key
      next_rx_lfsr = {rx_lfsr[9:0], ~rx_bit};
      next_run = (rx_pred == ~rx_bit) ? run + 5'h1 : 5'h0;
      if (rx_pred == ~rx_bit && run == fepcs_pkg::SYNC_RUN - 5'h1) begin
        next_locked = 1'b1;
        next_wd_cnt = 10'h000;
        next_run = 5'h0;
      end
    end else begin
      next_rx_lfsr = {rx_lfsr[9:0], rx_pred};
      next_win = {win[8:0], rx_bit ^ rx_pred};
      next_wd_cnt = (win == 10'h3FF) ? 10'h000 : wd_cnt + 10'h001;
      if (wd_expire) begin
        next_locked = 1'b0;
        next_wd_cnt = 10'h000;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_lvl <= fepcs_pkg::LVL_ZERO;
      rx_lvl_d <= fepcs_pkg::LVL_ZERO;
      rx_nrzi <= 1'b0;
      rx_nrzi_d <= 1'b0;
      rx_lfsr <= 11'h000;
      run <= 5'h0;
      wd_cnt <= 10'h000;
      win <= 10'h000;
      rx_locked <= 1'b0;
    end else begin
      rx_lvl <= next_rx_lvl;
      rx_lvl_d <= rx_lvl;
      rx_nrzi <= next_rx_nrzi;
      rx_nrzi_d <= rx_nrzi;
      rx_lfsr <= next_rx_lfsr;
      run <= next_run;
      wd_cnt <= next_wd_cnt;
      win <= next_win;
      rx_locked <= next_locked;
    end
  end

  // ---------------- receive framing ----------------
  fepcs_pkg::fepcs_rx_st_t rx_st, next_rx_st;
  logic [2:0] grp_cnt, next_grp_cnt;
  logic [3:0] pend, next_pend, next_rxd;
  logic pend_er, next_pend_er, end_t, next_end_t;
  logic next_rx_dv, next_rx_er, next_crs, next_nib_valid;
  logic bnd;
  logic [4:0] grp, grp_dec;

  always_comb begin
    bnd = (grp_cnt == fepcs_pkg::GRP_LAST);
    grp = win[4:0];
    grp_dec = fepcs_pkg::dec4(grp);
    next_grp_cnt = bnd ? 3'h0 : grp_cnt + 3'h1;
    next_rx_st = rx_st;
    next_pend = pend;
    next_pend_er = pend_er;
    next_end_t = end_t;
    next_rxd = rxd;
    next_rx_dv = rx_dv;
    next_rx_er = rx_er;
    next_crs = crs;
    next_nib_valid = 1'b0;
    if (wd_expire || !rx_locked) begin
      next_rx_st = fepcs_pkg::RX_IDLE;
      next_rx_dv = 1'b0;
      next_crs = 1'b0;
    end else begin
      unique case (rx_st)
        fepcs_pkg::RX_IDLE: begin
          // alignment taken from idle then j
          if (win == {fepcs_pkg::CG_I, fepcs_pkg::CG_J}) begin
            next_rx_st = fepcs_pkg::RX_SSD;
            next_grp_cnt = 3'h0;
            next_crs = 1'b1;
            next_rx_er = 1'b0;
          end
        end
        fepcs_pkg::RX_SSD: if (bnd) begin
          next_nib_valid = 1'b1;
          if (grp == fepcs_pkg::CG_K) begin
            next_rxd = fepcs_pkg::NIB_PRE;
            next_rx_dv = 1'b1;
            next_pend = fepcs_pkg::NIB_PRE;
            next_pend_er = 1'b0;
            next_rx_st = fepcs_pkg::RX_FRAME;
          end else begin
            next_rxd = fepcs_pkg::NIB_BAD_SSD;
            next_rx_er = 1'b1;
            next_crs = 1'b0;
            next_rx_st = fepcs_pkg::RX_IDLE;
          end
        end
        fepcs_pkg::RX_FRAME: if (bnd) begin
          // output runs one group behind the line
          next_nib_valid = 1'b1;
          next_rxd = pend;
          next_rx_er = pend_er;
          next_rx_dv = 1'b1;
          if (grp == fepcs_pkg::CG_T || grp == fepcs_pkg::CG_I) begin
            next_end_t = (grp == fepcs_pkg::CG_T);
            next_rx_st = fepcs_pkg::RX_END;
          end else begin
            next_pend = grp_dec[3:0];
            next_pend_er = ~grp_dec[4];
          end
        end
        fepcs_pkg::RX_END: if (bnd) begin
          next_nib_valid = 1'b1;
          next_rx_dv = 1'b0;
          next_crs = 1'b0;
          next_rx_er = (grp != (end_t ? fepcs_pkg::CG_R : fepcs_pkg::CG_I));
          next_rx_st = fepcs_pkg::RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_st <= fepcs_pkg::RX_IDLE;
      grp_cnt <= 3'h0;
      pend <= 4'h0;
      pend_er <= 1'b0;
      end_t <= 1'b0;
      rxd <= 4'h0;
      rx_dv <= 1'b0;
      rx_er <= 1'b0;
      crs <= 1'b0;
      rx_nib_valid <= 1'b0;
    end else begin
      rx_st <= next_rx_st;
      grp_cnt <= next_grp_cnt;
      pend <= next_pend;
      pend_er <= next_pend_er;
      end_t <= next_end_t;
      rxd <= next_rxd;
      rx_dv <= next_rx_dv;
      rx_er <= next_rx_er;
      crs <= next_crs;
      rx_nib_valid <= next_nib_valid;
    end
  end

  // ---------------- checks ----------------
  property p_tx_jk;
    @(posedge ref_clk) disable iff (srst)
      (tx_load && tx_st == fepcs_pkg::TX_IDLE && tx_en)
      |=> (tx_grp == fepcs_pkg::CG_J) ##5 (tx_grp == fepcs_pkg::CG_K);
  endproperty
  a_tx_jk: assert property (p_tx_jk) else $error("start delimiter wrong");
  property p_tx_tr;
    @(posedge ref_clk) disable iff (srst)
      (tx_load && tx_st == fepcs_pkg::TX_DATA && !tx_en)
      |=> (tx_grp == fepcs_pkg::CG_T) ##5 (tx_grp == fepcs_pkg::CG_R);
  endproperty
  a_tx_tr: assert property (p_tx_tr) else $error("end delimiter wrong");
  property p_tx_idle;
    @(posedge ref_clk) disable iff (srst)
      (tx_load && tx_st == fepcs_pkg::TX_IDLE && !tx_en) |=> (tx_grp == fepcs_pkg::CG_I);
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("idle not sent");
  property p_tx_err;
    @(posedge ref_clk) disable iff (srst)
      (tx_load && tx_st == fepcs_pkg::TX_DATA && tx_en && tx_er) |=> (tx_grp == fepcs_pkg::CG_H);
  endproperty
  a_tx_err: assert property (p_tx_err) else $error("error group not sent");
  property p_tx_valid;
    @(posedge ref_clk) disable iff (srst)
      fepcs_pkg::dec4(tx_grp) > 5'h0F || tx_grp == fepcs_pkg::CG_I || tx_grp == fepcs_pkg::CG_J
      || tx_grp == fepcs_pkg::CG_K || tx_grp == fepcs_pkg::CG_T || tx_grp == fepcs_pkg::CG_R
      || tx_grp == fepcs_pkg::CG_H;
  endproperty
  a_tx_valid: assert property (p_tx_valid) else $error("invalid group sent");
  property p_mlt_step;
    @(posedge ref_clk) disable iff (srst)
      1'b1 |=> (mlt_ph == $past(mlt_ph) + {1'b0, $past(tx_line_bit)});
  endproperty
  a_mlt_step: assert property (p_mlt_step) else $error("mlt3 did not step");
  property p_ssd_ok;
    @(posedge ref_clk) disable iff (srst || wd_expire)
      (rx_st == fepcs_pkg::RX_SSD && bnd && rx_locked && grp == fepcs_pkg::CG_K)
      |=> (rx_dv && rxd == fepcs_pkg::NIB_PRE) ##5 (rx_dv && rxd == fepcs_pkg::NIB_PRE);
  endproperty
  a_ssd_ok: assert property (p_ssd_ok) else $error("preamble nibbles wrong");
  property p_ssd_bad;
    @(posedge ref_clk) disable iff (srst)
      (rx_st == fepcs_pkg::RX_SSD && bnd && rx_locked && !wd_expire && grp != fepcs_pkg::CG_K)
      |=> (rx_er && !rx_dv && rxd == fepcs_pkg::NIB_BAD_SSD);
  endproperty
  a_ssd_bad: assert property (p_ssd_bad) else $error("bad delimiter not flagged");
  property p_wd;
    @(posedge ref_clk) disable iff (srst)
      wd_expire |=> (!rx_locked && !rx_dv && !crs);
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog did not abort");
  c_ssd_ok: cover property (@(posedge ref_clk) disable iff (srst) $rose(rx_dv));
  c_ssd_bad: cover property (@(posedge ref_clk) disable iff (srst) rx_er && !rx_dv);
  c_wd: cover property (@(posedge ref_clk) disable iff (srst) wd_expire);
  c_tx: cover property (@(posedge ref_clk) disable iff (srst) tx_st == fepcs_pkg::TX_R);

endmodule // fepcs_coding

// >>> testbench/fepcs_link_model.sv
`timescale 1ns/1ns
module fepcs_link_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // group to send, loaded at the edge where grp_req is high
  input wire logic [4:0] cg,
  output logic grp_req,
  // quantized line sample
  output logic [5:0] rx_sample
);
  logic [2:0] cnt;
  logic [4:0] sh;
  logic [10:0] lfsr;
  logic [1:0] ph;
  logic key;
  logic bit_l;
  assign grp_req = (cnt == 3'h4);
  assign key = lfsr[10] ^ lfsr[8];
  assign bit_l = sh[4] ^ key;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt <= 3'h0;
      sh <= 5'h1F;
      // any non-zero key start; value is arbitrary
      lfsr <= 11'h5A3;
      ph <= 2'h0;
    end else begin
      cnt <= grp_req ? 3'h0 : cnt + 3'h1;
      sh <= grp_req ? cg : {sh[3:0], 1'b0};
      lfsr <= {lfsr[9:0], key};
      // step the level on every toggle
      ph <= ph + {1'b0, bit_l};
    end
  end
  // phases 0,+,0,- sampled well clear of the slicer threshold
  assign rx_sample = !ph[0] ? 6'h00 : (ph[1] ? 6'h21 : 6'h1F);
endmodule // fepcs_link_model

// >>> testbench/test_fast_ethernet_pcs_coding.sv
`timescale 1ns/1ns
module test_fast_ethernet_pcs_coding;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [4:0] phy_addr = 5'h03;
  logic tx_en = 1'b0;
  logic tx_er = 1'b0;
  logic [3:0] txd = 4'h0;
  logic tx_nib_req, rx_dv, rx_er, crs, rx_nib_valid, rx_locked, grp_req;
  logic [1:0] mlt3_level, prev_lvl;
  logic [3:0] rxd;
  logic [5:0] rx_sample, m_sample;
  logic [4:0] cg = fepcs_pkg::CG_I;
  logic loopback = 1'b1;
  logic [5:0] rxq[$];
  int err_count = 0;
  int checks = 0;

  always #25 ref_clk = ~ref_clk;

  // loopback turns our own line levels into samples
  assign rx_sample = !loopback ? m_sample :
    (mlt3_level == fepcs_pkg::LVL_PLUS) ? 6'h1F :
    (mlt3_level == fepcs_pkg::LVL_MINUS) ? 6'h21 : 6'h00;

  fepcs_coding u_dut (.ref_clk(ref_clk), .srst(srst), .phy_addr(phy_addr), .tx_en(tx_en),
    .tx_er(tx_er), .txd(txd), .tx_nib_req(tx_nib_req), .mlt3_level(mlt3_level),
    .rx_sample(rx_sample), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .crs(crs),
    .rx_nib_valid(rx_nib_valid), .rx_locked(rx_locked));

  fepcs_link_model u_link (.ref_clk(ref_clk), .srst(srst), .cg(cg), .grp_req(grp_req),
    .rx_sample(m_sample));

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic timeout(input string name);
    $display("BAD %s exp done got timeout", name);
    err_count++;
    results();
  endtask

  always @(negedge ref_clk) begin
    prev_lvl <= mlt3_level;
    if (rx_nib_valid === 1'b1) begin
      rxq.push_back({rx_er, rx_dv, rxd});
    end
    if (srst === 1'b0) begin
      check("mlt3_step", 8'h00, {7'h00, (prev_lvl ^ mlt3_level) === 2'h2});
    end
  end

  task automatic do_reset(input logic lb, input logic [4:0] addr);
    @(posedge ref_clk);
    srst <= 1'b1;
    loopback <= lb;
    phy_addr <= addr;
    cg <= fepcs_pkg::CG_I;
    tx_en <= 1'b0;
    tx_er <= 1'b0;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
  endtask

  task automatic wait_lock();
    int i;
    for (i = 0; i < 3000 && rx_locked !== 1'b1; i++) @(negedge ref_clk);
    if (rx_locked !== 1'b1) timeout("lock");
    @(posedge ref_clk);
    rxq.delete();
  endtask

  // drive at a rising edge, return at the edge that takes the nibble
  task automatic mii(input logic en, input logic er, input logic [3:0] d);
    int i;
    tx_en <= en;
    tx_er <= er;
    txd <= d;
    // let the edge settle first, the previous take edge still shows the old strobe
    i = 0;
    do begin
      @(negedge ref_clk);
      i++;
    end while (i < 10 && tx_nib_req !== 1'b1);
    if (tx_nib_req !== 1'b1) timeout("tx_nib_req");
    @(posedge ref_clk);
  endtask

  task automatic grp(input logic [4:0] g);
    int i;
    cg <= g;
    i = 0;
    do begin
      @(negedge ref_clk);
      i++;
    end while (i < 10 && grp_req !== 1'b1);
    if (grp_req !== 1'b1) timeout("grp_req");
    @(posedge ref_clk);
  endtask

  function automatic logic [7:0] er_in_frame();
    logic f;
    f = 1'b0;
    foreach (rxq[i]) f |= (rxq[i][5:4] === 2'b11);
    return {7'h00, f};
  endfunction

  task automatic s_reset();
    do_reset(1'b1, 5'h03);
    @(negedge ref_clk);
    check("rst_out", 8'h00, {mlt3_level, tx_nib_req, rx_dv, rx_er, crs, rx_nib_valid, rx_locked});
    check("rst_rxd", 8'h00, {4'h0, rxd});
  endtask

  task automatic s_seed();
    logic [79:0] v[2];
    for (int a = 0; a < 2; a++) begin
      do_reset(1'b1, a ? 5'h1C : 5'h03);
      for (int c = 0; c < 40; c++) begin
        @(negedge ref_clk);
        v[a] = {v[a][77:0], mlt3_level};
      end
    end
    check("seed_diff", 8'h01, {7'h00, v[0] !== v[1]});
  endtask

  task automatic s_loop_frame();
    logic [3:0] exp[6] = '{4'h5, 4'h5, 4'h5, 4'hD, 4'hA, 4'h3};
    do_reset(1'b1, 5'h07);
    wait_lock();
    mii(1'b1, 1'b0, 4'h5);
    mii(1'b1, 1'b0, 4'h5);
    for (int i = 2; i < 6; i++) mii(1'b1, 1'b0, exp[i]);
    repeat (5) mii(1'b0, 1'b0, 4'h0);
    repeat (40) @(posedge ref_clk);
    while (rxq.size() > 0 && rxq[0][4] !== 1'b1) void'(rxq.pop_front());
    if (rxq.size() < 7) timeout("rx_frame");
    foreach (exp[i]) check("rx_nib", {4'h1, exp[i]}, {2'b00, rxq[i]});
    check("rx_end", 8'h00, {6'h00, rxq[6][5:4]});
    check("crs_end", 8'h00, {6'h00, crs, rx_dv});
  endtask

  task automatic s_tx_err();
    do_reset(1'b1, 5'h11);
    wait_lock();
    repeat (3) mii(1'b1, 1'b0, 4'h5);
    mii(1'b1, 1'b1, 4'h3);
    mii(1'b1, 1'b0, 4'h7);
    repeat (5) mii(1'b0, 1'b0, 4'h0);
    repeat (40) @(posedge ref_clk);
    check("tx_err_rx", 8'h01, er_in_frame());
  endtask

  task automatic s_bad_ssd();
    do_reset(1'b0, 5'h03);
    wait_lock();
    grp(fepcs_pkg::CG_J);
    grp(5'h1E);
    repeat (3) grp(fepcs_pkg::CG_I);
    @(negedge ref_clk);
    check("bad_ssd", 8'h2E, {2'b00, rx_er, rx_dv, rxd});
    // a frame closed by two idles instead of t/r
    rxq.delete();
    grp(fepcs_pkg::CG_J);
    grp(fepcs_pkg::CG_K);
    grp(5'h1E);
    repeat (4) grp(fepcs_pkg::CG_I);
    check("idle_cnt", 8'h04, 8'(rxq.size()));
    check("idle_end", 8'h00, {2'b00, rxq[3]});
    check("idle_crs", 8'h00, {6'h00, crs, rx_dv});
  endtask

  task automatic s_invalid();
    logic [4:0] bad[9] = '{5'h19, 5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h08, 5'h0C, 5'h10};
    do_reset(1'b0, 5'h03);
    wait_lock();
    foreach (bad[k]) begin
      rxq.delete();
      grp(fepcs_pkg::CG_J);
      grp(fepcs_pkg::CG_K);
      grp(5'h1E);
      grp(bad[k]);
      grp(5'h1E);
      grp(fepcs_pkg::CG_T);
      grp(fepcs_pkg::CG_R);
      repeat (4) grp(fepcs_pkg::CG_I);
      check("inv_cg", 8'h01, er_in_frame());
    end
  endtask

  task automatic s_watchdog();
    int n;
    do_reset(1'b0, 5'h03);
    wait_lock();
    grp(fepcs_pkg::CG_J);
    grp(fepcs_pkg::CG_K);
    cg <= 5'h1E;
    for (n = 0; n < 1200 && rx_locked === 1'b1; n++) @(negedge ref_clk);
    if (rx_locked === 1'b1) timeout("watchdog");
    check("wd_time", 8'h01, {7'h00, n >= 700 && n <= 850});
    @(negedge ref_clk);
    check("wd_abort", 8'h00, {6'h00, rx_dv, crs});
    @(posedge ref_clk);
    cg <= fepcs_pkg::CG_I;
    wait_lock();
    check("relock", 8'h01, {7'h00, rx_locked});
  endtask

  initial begin
    s_reset();
    s_seed();
    s_loop_frame();
    s_tx_err();
    s_bad_ssd();
    s_invalid();
    s_watchdog();
    results();
  end
endmodule // test_fast_ethernet_pcs_coding
